// ### thbm_top.sv
// Two-hand control logic with bypass of the first station and muting.
// Field inputs are asynchronous to mclk_i; registers sit on a plain port
// with read data one cycle after the read strobe.
//
// Overview of operation
// - Stations act only through this block or via bypass; four at most.
// - With gating configured, gating input must be on before output on.
// - Unmuted station or stop device leaving Run forces output off.
// - Stop device must be in Run before stations can switch on.
// - Bypass switch may reach Run before or after stop device.
// - With stop device in Run, last of station or bypass starts output.
// - Bypassed station and bypass switch together turn both outputs off.
// - Bypass block on only when exactly one of station or bypass is Run.
// - Bypassing first station lets second station alone start output.
// - Unbypassed first station must be actuated together with second.
// - First station and bypass both Run prevent or end output.
// - Only selected stations are muted; others keep turn-off authority.
// - Actuating all stations starts a cycle regardless of mute enable.
// - After release, mute sensors hold output only with mute enable on.
// - Stations in Run at power-up keep output off.
// - After power-up stations must go Stop then Run before output.
// - No manual reset; output follows two-hand logic directly.
// - All selected stations must be actuated before output on.
// - Gating off means station actuation changes nothing.
// - Output on and unmuted station input off turns output off.
// - After gating returns, output stays off until stations cycle.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module thbm_top #(
	parameter int NSTA = thbm_pkg::MAX_STATIONS
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire thbm_pkg::thbm_in_s field_i,
	input wire logic [thbm_pkg::ADDR_W-1:0] addr_i,
	input wire logic [thbm_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [thbm_pkg::DATA_W-1:0] rdata_o,
	output logic safety_output_o,
	output logic bypass_block_o
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (NSTA < 1 || NSTA > thbm_pkg::MAX_STATIONS)
	begin : g_bad
		$error("NSTA must be 1 to 4");
	end

	// ----------------------------------------------------------------
	// Input synchroniser
	// ----------------------------------------------------------------
	thbm_pkg::thbm_in_s meta_r, meta_nxt;
	thbm_pkg::thbm_in_s smp_r, smp_nxt;
	logic [thbm_pkg::SYNC_STAGES-1:0] vld_r, vld_nxt;

	always_comb
	begin
		meta_nxt = field_i;
		smp_nxt = meta_r;
		vld_nxt = {vld_r[thbm_pkg::SYNC_STAGES-2:0], 1'b1};
	end

	// Sampled every clock; the first stage feeds only the second
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			meta_r <= '0;
			smp_r <= '0;
			vld_r <= '0;
		end
		else
		begin
			meta_r <= meta_nxt;
			smp_r <= smp_nxt;
			vld_r <= vld_nxt;
		end
	end

	// Reset values of the sampler look like released stations, so
	// arming waits until real samples have arrived
	logic vld;
	assign vld = vld_r[thbm_pkg::SYNC_STAGES-1];

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	thbm_pkg::thbm_cfg_s cfg_r, cfg_nxt;

	always_comb
	begin
		cfg_nxt = cfg_r;
		if (wr_i && addr_i == thbm_pkg::CTRL_OFS)
		begin
			cfg_nxt.gate_en = wdata_i[thbm_pkg::CTRL_GATE_EN_BIT];
			cfg_nxt.byp_en = wdata_i[thbm_pkg::CTRL_BYP_EN_BIT];
			cfg_nxt.cnt_m1 = wdata_i[thbm_pkg::CTRL_CNT_LSB +: thbm_pkg::CTRL_CNT_W];
			cfg_nxt.mute_sel = wdata_i[thbm_pkg::CTRL_MSEL_LSB +: 4];
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cfg_r.gate_en <= thbm_pkg::CTRL_GATE_EN_RST;
			cfg_r.byp_en <= thbm_pkg::CTRL_BYP_EN_RST;
			cfg_r.cnt_m1 <= thbm_pkg::CTRL_CNT_RST;
			cfg_r.mute_sel <= thbm_pkg::CTRL_MSEL_RST;
		end
		else
		begin
			cfg_r <= cfg_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Station evaluation
	// ----------------------------------------------------------------
	logic [3:0] mask;
	logic [3:0] raw;
	logic [3:0] eff;
	logic [3:0] msel;
	logic conflict;

	genvar gi;
	for (gi = 0; gi < 4; gi++)
	begin : g_sta
		// Stations beyond NSTA or the configured count never count
		assign mask[gi] = (gi < NSTA) && (gi <= int'(cfg_r.cnt_m1));
		assign raw[gi] = smp_r.stations[gi] & mask[gi];
		assign msel[gi] = cfg_r.mute_sel[gi] & mask[gi];
		if (gi == 0)
		begin : g_byp
			// First station may be replaced by the bypass switch, never both
			assign eff[gi] = cfg_r.byp_en ?
				(raw[gi] ^ smp_r.bypass_switch) : raw[gi];
		end
		else
		begin : g_dir
			assign eff[gi] = raw[gi];
		end
	end

	assign conflict = cfg_r.byp_en & raw[0] & smp_r.bypass_switch;

	logic all_eff;
	logic unmuted_ok;
	logic muted_ok;
	logic raw_off;
	logic gate_ok;
	logic stop_ok;
	logic mute_act;

	always_comb
	begin
		all_eff = &(eff | ~mask);
		unmuted_ok = &(eff | ~mask | msel);
		muted_ok = &(eff | ~mask | ~msel);
		raw_off = ~|raw;
		gate_ok = !cfg_r.gate_en || smp_r.gate;
		stop_ok = smp_r.stop_device;
		mute_act = smp_r.mute_enable & smp_r.mute_sensors;
	end

	// ----------------------------------------------------------------
	// Sequencing and output
	// ----------------------------------------------------------------
	logic arm_r, arm_nxt;
	logic out_r, out_nxt;
	logic bblk_r, bblk_nxt;
	logic start;
	logic hold;

	always_comb
	begin
		// Arming uses the raw stations, so the bypass switch may settle
		// in any order against the stop device
		arm_nxt = arm_r;
		if (vld && raw_off)
		begin
			arm_nxt = 1'b1;
		end
		else if (!stop_ok || !gate_ok)
		begin
			arm_nxt = 1'b0;
		end
		start = arm_r && stop_ok && gate_ok && all_eff && !conflict;
		hold = out_r && stop_ok && gate_ok && !conflict && unmuted_ok &&
			(muted_ok || mute_act);
		out_nxt = start || hold;
		bblk_nxt = cfg_r.byp_en && eff[0] && !conflict;
	end

	// Arm starts cleared: stations held at power-up cannot start
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			arm_r <= 1'b0;
			out_r <= 1'b0;
			bblk_r <= 1'b0;
		end
		else
		begin
			arm_r <= arm_nxt;
			out_r <= out_nxt;
			bblk_r <= bblk_nxt;
		end
	end

	assign safety_output_o = out_r;
	assign bypass_block_o = bblk_r;

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	logic [thbm_pkg::DATA_W-1:0] rdata_r, rdata_nxt;

	always_comb
	begin
		rdata_nxt = '0;
		if (rd_i && addr_i == thbm_pkg::CTRL_OFS)
		begin
			rdata_nxt[thbm_pkg::CTRL_GATE_EN_BIT] = cfg_r.gate_en;
			rdata_nxt[thbm_pkg::CTRL_BYP_EN_BIT] = cfg_r.byp_en;
			rdata_nxt[thbm_pkg::CTRL_CNT_LSB +: thbm_pkg::CTRL_CNT_W] = cfg_r.cnt_m1;
			rdata_nxt[thbm_pkg::CTRL_MSEL_LSB +: 4] = cfg_r.mute_sel;
		end
		else if (rd_i && addr_i == thbm_pkg::STAT_OFS)
		begin
			rdata_nxt[thbm_pkg::STAT_OUT_BIT] = out_r;
			rdata_nxt[thbm_pkg::STAT_ARM_BIT] = arm_r;
			rdata_nxt[thbm_pkg::STAT_STOP_BIT] = smp_r.stop_device;
			rdata_nxt[thbm_pkg::STAT_GATE_BIT] = smp_r.gate;
			rdata_nxt[thbm_pkg::STAT_BYP_BIT] = smp_r.bypass_switch;
			rdata_nxt[thbm_pkg::STAT_MUTE_BIT] = mute_act;
			rdata_nxt[thbm_pkg::STAT_BYPBLK_BIT] = bblk_r;
			rdata_nxt[thbm_pkg::STAT_STA_LSB +: 4] = smp_r.stations;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rdata_r <= '0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata_o = rdata_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);

	AST_STOP_OFF: assert property (
		!stop_ok |=> !out_r)
		else $error("Output on after stop device left Run");

	AST_GATE_OFF: assert property (
		(cfg_r.gate_en && !smp_r.gate) |=> !out_r)
		else $error("Output on while gating input off");

	AST_CONFLICT: assert property (
		conflict |=> (!out_r && !bblk_r))
		else $error("Output on with station and bypass both in Run");

	AST_UNARMED: assert property (
		(!out_r && !arm_r) |=> !out_r)
		else $error("Output started without arming");

	AST_STA_DROP: assert property (
		(out_r && !unmuted_ok) |=> !out_r)
		else $error("Output held after unmuted station released");

	AST_MUTE_END: assert property (
		(out_r && !muted_ok && !mute_act) |=> !out_r)
		else $error("Output held by mute without mute enable");

	AST_START: assert property (
		(arm_r && stop_ok && gate_ok && all_eff && !conflict) |=> out_r)
		else $error("Output failed to start");

	AST_POWERUP: assert property (
		$rose(out_r) |-> $past(arm_r))
		else $error("Output rose without a prior release");

	AST_GATE_REARM: assert property (
		(cfg_r.gate_en && !smp_r.gate && !raw_off) |=>
			!arm_r ##1 (!arm_r || $past(raw_off)))
		else $error("Armed while gating off and stations held");

	AST_RDATA: assert property (
		!$past(rd_i) |-> rdata_o == '0)
		else $error("Read data outside read answer cycle");

	// Strobes never coincide, so config cannot move under a read
	AST_RDATA_CTRL: assert property (
		(rd_i && addr_i == thbm_pkg::CTRL_OFS) |=>
			rdata_o[thbm_pkg::CTRL_BYP_EN_BIT] == cfg_r.byp_en)
		else $error("Control read answer does not match config");

	AST_BYP_EXCL: assert property (
		(!cfg_r.byp_en || (raw[0] == smp_r.bypass_switch)) |=> !bblk_r)
		else $error("Bypass block on without exactly one source in Run");

	AST_BYP_ON: assert property (
		(cfg_r.byp_en && !raw[0] && smp_r.bypass_switch) |=> bblk_r)
		else $error("Bypass block failed to follow the bypass switch");

	AST_ALL_STA: assert property (
		(!out_r && !all_eff) |=> !out_r)
		else $error("Output started before every station was actuated");

	AST_STOP_DISARM: assert property (
		(!stop_ok && !raw_off) |=> !arm_r)
		else $error("Armed while stop device off and stations held");

	AST_MUTE_HOLD: assert property (
		(out_r && stop_ok && gate_ok && !conflict && unmuted_ok &&
			mute_act) |=> out_r)
		else $error("Muted output dropped while mute active");

	AST_EARLY_ARM: assert property (
		!vld |-> !arm_r)
		else $error("Armed before field samples were valid");

	AST_RELEASE_ARM: assert property (
		(vld && raw_off) |=> arm_r)
		else $error("Released stations did not arm");

endmodule

`default_nettype wire

// ### thbm_pkg.sv
// Package for the two-hand control block with bypass and muting.
// Assumes a single system clock; used by thbm_top, the field model and the bench.
package thbm_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;

	// ----------------------------------------------------------------
	// Control register fields and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_GATE_EN_BIT = 0;
	localparam int CTRL_BYP_EN_BIT = 1;
	localparam int CTRL_CNT_LSB = 2;
	localparam int CTRL_CNT_W = 2;
	localparam int CTRL_MSEL_LSB = 4;
	localparam logic CTRL_GATE_EN_RST = 1'b0;
	localparam logic CTRL_BYP_EN_RST = 1'b0;
	localparam logic [1:0] CTRL_CNT_RST = 2'h0;
	localparam logic [3:0] CTRL_MSEL_RST = 4'h0;

	// ----------------------------------------------------------------
	// Status register fields
	// ----------------------------------------------------------------
	localparam int STAT_OUT_BIT = 0;
	localparam int STAT_ARM_BIT = 1;
	localparam int STAT_STOP_BIT = 2;
	localparam int STAT_GATE_BIT = 3;
	localparam int STAT_BYP_BIT = 4;
	localparam int STAT_MUTE_BIT = 5;
	localparam int STAT_BYPBLK_BIT = 6;
	localparam int STAT_STA_LSB = 8;

	// ----------------------------------------------------------------
	// Timing: synchroniser depth before inputs count as valid
	// ----------------------------------------------------------------
	localparam int SYNC_STAGES = 2;
	localparam int MAX_STATIONS = 4;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] stations;
		logic stop_device;
		logic gate;
		logic bypass_switch;
		logic mute_sensors;
		logic mute_enable;
	} thbm_in_s;

	typedef struct packed {
		logic gate_en;
		logic byp_en;
		logic [1:0] cnt_m1;
		logic [3:0] mute_sel;
	} thbm_cfg_s;

endpackage

// ### thbm_field_model.sv
// Field-side model: operator stations, stop device, gate, bypass, mute.
// Assumes requests from the bench; all lines change just after mclk_i.
`timescale 1ns/1ps
`default_nettype none

module thbm_field_model (
	input wire logic mclk_i,
	input wire thbm_pkg::thbm_in_s req_i,
	output thbm_pkg::thbm_in_s field_o
);
	thbm_pkg::thbm_in_s fld_r = '0;
	thbm_pkg::thbm_in_s fld_nxt;

	// ----------------------------------------------------------------
	// Operator behaviour
	// ----------------------------------------------------------------
	always_comb
	begin
		fld_nxt = req_i;
		// A new press waits until the stop device is in Run
		if (!fld_r.stop_device)
		begin
			fld_nxt.stations = req_i.stations & fld_r.stations;
		end
	end
	always_ff @(posedge mclk_i)
	begin
		fld_r <= fld_nxt;
	end
	assign field_o = fld_r;
endmodule
`default_nettype wire

// ### thbm_top_test.sv
// Self-checking bench for thbm_top with field model and register port.
// Assumes output answers 3 edges after a field change.
`timescale 1ns/1ps
`default_nettype none

module thbm_top_test;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [8:0] fld;
		logic out;
		logic byp;
		logic chk;
	} thbm_row_s;

	logic mclk_i = 1'b0;
	logic arst_n_i = 1'b0;
	thbm_pkg::thbm_in_s req = 9'h038;
	thbm_pkg::thbm_in_s field;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic safety_output_o;
	logic bypass_block_o;
	logic [31:0] rd_v;
	int fails = 0;
	int n_tests = 0;
	thbm_row_s rows [26] = '{
		'{8'h04, 9'h018, 1'b0, 1'b0, 1'b0}, '{8'h04, 9'h078, 1'b1, 1'b0, 1'b0},
		'{8'h04, 9'h038, 1'b0, 1'b0, 1'b0}, '{8'h04, 9'h018, 1'b0, 1'b0, 1'b0},
		'{8'h04, 9'h078, 1'b1, 1'b0, 1'b0}, '{8'h04, 9'h068, 1'b0, 1'b0, 1'b0},
		'{8'h04, 9'h078, 1'b0, 1'b0, 1'b0}, '{8'h04, 9'h018, 1'b0, 1'b0, 1'b0},
		'{8'h06, 9'h018, 1'b0, 1'b0, 1'b1}, '{8'h06, 9'h058, 1'b0, 1'b0, 1'b0},
		'{8'h06, 9'h05C, 1'b1, 1'b1, 1'b1}, '{8'h06, 9'h07C, 1'b0, 1'b0, 1'b1},
		'{8'h06, 9'h018, 1'b0, 1'b0, 1'b0}, '{8'h05, 9'h010, 1'b0, 1'b0, 1'b0},
		'{8'h05, 9'h070, 1'b0, 1'b0, 1'b0}, '{8'h05, 9'h078, 1'b0, 1'b0, 1'b0},
		'{8'h05, 9'h018, 1'b0, 1'b0, 1'b0}, '{8'h05, 9'h078, 1'b1, 1'b0, 1'b0},
		'{8'h14, 9'h01B, 1'b0, 1'b0, 1'b0}, '{8'h14, 9'h07B, 1'b1, 1'b0, 1'b0},
		'{8'h14, 9'h05B, 1'b1, 1'b0, 1'b0}, '{8'h14, 9'h01B, 1'b0, 1'b0, 1'b0},
		'{8'h14, 9'h079, 1'b1, 1'b0, 1'b0}, '{8'h14, 9'h059, 1'b0, 1'b0, 1'b0},
		'{8'h06, 9'h00C, 1'b0, 1'b1, 1'b1}, '{8'h06, 9'h05C, 1'b1, 1'b1, 1'b1}};

	always #20 mclk_i = ~mclk_i;

	thbm_field_model u_field (.mclk_i(mclk_i), .req_i(req), .field_o(field));

	thbm_top u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .field_i(field),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .safety_output_o(safety_output_o),
		.bypass_block_o(bypass_block_o));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask

	// Read data is only valid in the cycle after the strobe
	task automatic bus_rd(input logic [7:0] a);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 rd_v = rdata_o;
	endtask

	task automatic apply(input logic [8:0] f, input int n);
		@(posedge mclk_i);
		req <= f;
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge mclk_i);
		check("out_in_reset", {31'h0, safety_output_o}, 32'h0);
		arst_n_i <= 1'b1;
		apply(9'h038, 8);
		check("powerup_held", {31'h0, safety_output_o}, 32'h0);
		apply(9'h018, 6);
		apply(9'h038, 6);
		check("powerup_recycle", {31'h0, safety_output_o}, 32'h1);
		$display("test power_up done");
		bus_rd(thbm_pkg::STAT_OFS);
		check("stat_out", {31'h0, rd_v[0]}, 32'h1);
		bus_rd(thbm_pkg::CTRL_OFS);
		check("ctrl_reset", rd_v, 32'h0);
		bus_wr(thbm_pkg::STAT_OFS, 32'hFF);
		bus_wr(8'h08, 32'hFF);
		bus_rd(thbm_pkg::CTRL_OFS);
		check("ctrl_untouched", rd_v, 32'h0);
		bus_rd(8'h08);
		check("unmapped_rd", rd_v, 32'h0);
		$display("test registers done");
		// Sequencing, bypass, gating and muting steps
		foreach (rows[i])
		begin
			bus_wr(thbm_pkg::CTRL_OFS, {24'h0, rows[i].ctrl});
			apply(rows[i].fld, 6);
			check("safety_out", {31'h0, safety_output_o},
				{31'h0, rows[i].out});
			if (rows[i].chk)
				check("bypass_blk", {31'h0, bypass_block_o},
					{31'h0, rows[i].byp});
		end
		// above
		$display("test table done");
		// Mid-run reset with both hands held
		apply(9'h078, 6);
		arst_n_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		check("out_reset_mid", {31'h0, safety_output_o}, 32'h0);
		arst_n_i <= 1'b1;
		apply(9'h078, 8);
		check("held_after_reset", {31'h0, safety_output_o}, 32'h0);
		bus_rd(thbm_pkg::CTRL_OFS);
		check("ctrl_after_reset", rd_v, 32'h0);
		apply(9'h018, 6);
		apply(9'h038, 6);
		check("recycle_after_reset", {31'h0, safety_output_o}, 32'h1);
		$display("test mid_reset done");
		complete_run();
	end

	// Guard against a hung run
	initial
	begin
		#2000000;
		fails++;
		complete_run();
	end
endmodule
`default_nettype wire
